// [asi_master_mode_panel.sv]
// Mode control, front-panel display and I/O window of the field-bus master.
// Assumes the line engine supplies detected/present slave sets on clk_i
// and an Avalon-MM master that honours waitrequest.
`timescale 1ns/1ns
`default_nettype none
`include "asi_panel_defines.svh"

module asi_master_mode_panel #(
  parameter int ROTATE_CYCLES = `ROTATE_CYC,
  parameter int FLASH_CYCLES  = `FLASH_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        button_i,
  input  wire logic [63:0] detected_i,
  input  wire logic [63:0] cfg_match_i,
  input  wire logic [31:0] slave_in_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [9:0]       unit_led_o,
  output logic             tens10_led_o,
  output logic             tens20_led_o,
  output logic             area_b_led_o,
  output logic             config_mode_indicator_o,
  output logic             config_error_indicator_o,
  output logic             system_fault_indicator_o,
  output logic [63:0]      exchange_en_o,
  output logic [31:0]      slave_out_o,
  output logic             nv_write_o
);
  // =====================================================================
  // Helpers
  // Configured = expected, present at address and configuration data match
  function automatic logic [63:0] configured(input logic [63:0] exp,
                                             input logic [63:0] det,
                                             input logic [63:0] mat);
    configured = exp & det & mat;
  endfunction
  // Pick ten slaves of a group out of a 64-bit set (bit 32+ is area B)
  // Offset is taken within the area, so group 3 shows only slaves 30 and 31
  function automatic logic [9:0] group_bits(input logic [63:0] s,
                                            input logic [2:0]  g);
    logic [5:0] off;
    for (int i = 0; i < 10; i++) begin
      off           = 6'(10 * g[1:0] + i);
      group_bits[i] = (off < 6'd32) ? s[{g[2], off[4:0]}] : 1'b0;
    end
  endfunction
  logic press;
  asi_button_sync #(
    .DEBOUNCE (`DEBOUNCE_CYC)
  ) u_btn (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .button_i (button_i),
    .press_o  (press)
  );

  // =====================================================================
  // Mode and store state
  asi_panel_pkg::mode_t  mode_ff,   nxt_mode;
  asi_panel_pkg::store_t st_ff,     nxt_st;
  logic [63:0]           expected_ff, nxt_expected;
  logic [3:0]            param_ff,  nxt_param;
  logic                  auto_ff,   nxt_auto;
  logic                  cer_ff,    nxt_cer;
  logic                  sf_ff,     nxt_sf;
  logic                  nvw_ff,    nxt_nvw;
  logic                  stop_ff,   nxt_stop;
  logic                  pwr_ff,    nxt_pwr;
  logic                  cm_ff,     nxt_cm;
  logic [63:0]           cfg_now;
  logic                  bus_wr;
  assign bus_wr  = avs_write_i && !avs_waitrequest_o;
  assign cfg_now = configured(expected_ff, detected_i, cfg_match_i);
  // Mode sequence: store first, switch one cycle later
  always_comb begin
    nxt_mode     = mode_ff;
    nxt_st       = st_ff;
    nxt_expected = expected_ff;
    nxt_param    = param_ff;
    nxt_auto     = auto_ff;
    nxt_cer      = cer_ff;
    nxt_sf       = sf_ff;
    nxt_nvw      = 1'b0;
    nxt_stop     = stop_ff;
    nxt_pwr      = pwr_ff;
    if (bus_wr && avs_address_i == `REG_CTRL) begin
      nxt_stop = avs_writedata_i[`CTRL_CPU_STOP];
      nxt_pwr  = avs_writedata_i[`CTRL_LINE_PWR];
    end
    // Error flag follows mismatch in protected mode
    if (mode_ff == asi_panel_pkg::MODE_PROTECT) begin
      nxt_cer = (detected_i != cfg_now) || (expected_ff != cfg_now);
    end
    unique case (st_ff)
      asi_panel_pkg::ST_IDLE: begin
        if (press && stop_ff) begin
          if (mode_ff == asi_panel_pkg::MODE_PROTECT) begin
            nxt_mode = asi_panel_pkg::MODE_CONFIG;
          end else if (detected_i[0]) begin
            nxt_sf = 1'b1;
          end else begin
            nxt_st = asi_panel_pkg::ST_STORE;
          end
        end
      end
      asi_panel_pkg::ST_STORE: begin
        nxt_nvw = 1'b1;
        nxt_sf  = 1'b0;
        if (!pwr_ff || detected_i == 64'h0) begin
          nxt_expected = 64'h0;
          nxt_param    = `PARAM_DEFAULT;
          nxt_auto     = `AUTO_ADDR_RST;
        end else begin
          nxt_expected = detected_i;
        end
        nxt_st = asi_panel_pkg::ST_SWITCH;
      end
      asi_panel_pkg::ST_SWITCH: begin
        nxt_mode = asi_panel_pkg::MODE_PROTECT;
        nxt_cer  = 1'b0;
        nxt_st   = asi_panel_pkg::ST_IDLE;
      end
      default: nxt_st = asi_panel_pkg::ST_IDLE;
    endcase
    // Processor-loaded set overrides any button store
    if (bus_wr && avs_address_i == `REG_EXPECTED) begin
      nxt_expected[31:0] = avs_writedata_i;
      nxt_nvw            = 1'b1;
    end
    if (bus_wr && avs_address_i == `REG_EXPECTED + 8'h04) begin
      nxt_expected[63:32] = avs_writedata_i;
      nxt_nvw             = 1'b1;
    end
    if (bus_wr && avs_address_i == `REG_PARAM) begin
      nxt_param = avs_writedata_i[3:0];
      nxt_auto  = avs_writedata_i[4];
    end
    nxt_cm = (nxt_mode == asi_panel_pkg::MODE_CONFIG);
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_ff     <= asi_panel_pkg::MODE_CONFIG;
      cm_ff       <= 1'b1;
      st_ff       <= asi_panel_pkg::ST_IDLE;
      expected_ff <= 64'h0;
      param_ff    <= `PARAM_DEFAULT;
      auto_ff     <= `AUTO_ADDR_RST;
      cer_ff      <= 1'b0;
      sf_ff       <= 1'b0;
      nvw_ff      <= 1'b0;
      stop_ff     <= 1'b0;
      pwr_ff      <= 1'b0;
    end else begin
      mode_ff     <= nxt_mode;
      st_ff       <= nxt_st;
      expected_ff <= nxt_expected;
      param_ff    <= nxt_param;
      auto_ff     <= nxt_auto;
      cer_ff      <= nxt_cer;
      sf_ff       <= nxt_sf;
      nvw_ff      <= nxt_nvw;
      stop_ff     <= nxt_stop;
      pwr_ff      <= nxt_pwr;
      cm_ff       <= nxt_cm;
    end
  end

  // =====================================================================
  // Display rotation and flash timers
  logic [31:0] rot_cnt_ff, nxt_rot_cnt;
  logic [31:0] fl_cnt_ff,  nxt_fl_cnt;
  logic [2:0]  grp_ff,     nxt_grp;
  logic        blink_ff,   nxt_blink;
  logic [9:0]  unit_ff,    nxt_unit;
  logic [63:0] xchg_ff,    nxt_xchg;
  // Groups 0..3 area A, 4..7 area B; period set by parameter
  always_comb begin
    nxt_rot_cnt = rot_cnt_ff + 32'h1;
    nxt_grp     = grp_ff;
    nxt_fl_cnt  = fl_cnt_ff + 32'h1;
    nxt_blink   = blink_ff;
    if (rot_cnt_ff == 32'(ROTATE_CYCLES - 1)) begin
      nxt_rot_cnt = 32'h0;
      nxt_grp     = grp_ff + 3'h1;
    end
    if (fl_cnt_ff == 32'(FLASH_CYCLES - 1)) begin
      nxt_fl_cnt = 32'h0;
      nxt_blink  = !blink_ff;
    end
    if (mode_ff == asi_panel_pkg::MODE_CONFIG) begin
      nxt_unit = group_bits(detected_i, grp_ff);
      nxt_xchg = detected_i;
    end else begin
      nxt_unit = group_bits(cfg_now, grp_ff)
               | (group_bits(cfg_now ^ (expected_ff | detected_i), grp_ff)
                  & {10{blink_ff}});
      nxt_xchg = cfg_now;
    end
    nxt_xchg[0] = 1'b0; // Address 0 never in cyclic exchange
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rot_cnt_ff <= 32'h0;
      fl_cnt_ff  <= 32'h0;
      grp_ff     <= 3'h0;
      blink_ff   <= 1'b0;
      unit_ff    <= 10'h000;
      xchg_ff    <= 64'h0;
    end else begin
      rot_cnt_ff <= nxt_rot_cnt;
      fl_cnt_ff  <= nxt_fl_cnt;
      grp_ff     <= nxt_grp;
      blink_ff   <= nxt_blink;
      unit_ff    <= nxt_unit;
      xchg_ff    <= nxt_xchg;
    end
  end

  // =====================================================================
  // Avalon slave: one wait cycle, then answer; output window storage
  logic        wait_ff,  nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] wout_ff,  nxt_wout;
  logic [2:0]  gled_ff;
  always_comb begin
    nxt_wait  = !((avs_read_i || avs_write_i) && wait_ff);
    nxt_rdata = rdata_ff;
    nxt_wout  = wout_ff;
    if (avs_read_i && wait_ff) begin
      unique case (avs_address_i)
        `REG_CTRL:     nxt_rdata = {29'h0, pwr_ff, 1'b0, stop_ff};
        `REG_STATUS:   nxt_rdata = {28'h0, auto_ff, sf_ff, cer_ff,
                                    mode_ff == asi_panel_pkg::MODE_CONFIG};
        `REG_DETECTED: nxt_rdata = detected_i[31:0];
        `REG_EXPECTED: nxt_rdata = expected_ff[31:0];
        `REG_ACTIVE:   nxt_rdata = cfg_now[31:0];
        `REG_PARAM:    nxt_rdata = {27'h0, auto_ff, param_ff};
        `REG_WIN_IN, `REG_WIN_IN + 8'h04, `REG_WIN_IN + 8'h08:
          nxt_rdata = 32'h0; // Lower window words kept for later use
        `REG_WIN_IN + 8'h0C: nxt_rdata = {slave_in_i[31:4], 4'h0};
        `REG_WIN_OUT + 8'h0C: nxt_rdata = {wout_ff[31:4], 4'h0};
        default:       nxt_rdata = `UNMAPPED_DATA;
      endcase
    end
    if (bus_wr && avs_address_i == `REG_WIN_OUT + 8'h0C) begin
      nxt_wout = {avs_writedata_i[31:4], 4'h0}; // reserved nibble
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
      wout_ff  <= 32'h0;
      gled_ff  <= 3'h0;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      wout_ff  <= nxt_wout;
      gled_ff  <= grp_ff;
    end
  end

  // All outputs come straight from flip-flops
  assign avs_readdata_o           = rdata_ff;
  assign avs_waitrequest_o        = wait_ff;
  assign unit_led_o               = unit_ff;
  assign tens10_led_o             = gled_ff[0];
  assign tens20_led_o             = gled_ff[1];
  assign area_b_led_o             = gled_ff[2];
  assign config_mode_indicator_o  = cm_ff;
  assign config_error_indicator_o = cer_ff;
  assign system_fault_indicator_o = sf_ff;
  assign exchange_en_o            = xchg_ff;
  assign slave_out_o              = wout_ff;
  assign nv_write_o               = nvw_ff;
  // =====================================================================
  // Checks
  sequence s_store;
    st_ff == asi_panel_pkg::ST_STORE ##1 st_ff == asi_panel_pkg::ST_SWITCH;
  endsequence

  a_press_ignored: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (press && !stop_ff) |=> $stable(mode_ff) && st_ff == asi_panel_pkg::ST_IDLE)
    else $error("press accepted while processor running");
  a_store_then_prot: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_store |=> mode_ff == asi_panel_pkg::MODE_PROTECT && $past(nvw_ff))
    else $error("store did not precede protected mode");
  a_back_to_cfg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (press && stop_ff && mode_ff == asi_panel_pkg::MODE_PROTECT
     && st_ff == asi_panel_pkg::ST_IDLE) |=> mode_ff == asi_panel_pkg::MODE_CONFIG)
    else $error("protected mode not left on press");
  a_cm_led_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(mode_ff == asi_panel_pkg::MODE_PROTECT) |-> !config_mode_indicator_o)
    else $error("config indicator lit in protected mode");
  a_cer_cleared: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_store |=> !config_error_indicator_o)
    else $error("error indicator not cleared after store");
  a_slave0_fault: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (press && stop_ff && detected_i[0] && st_ff == asi_panel_pkg::ST_IDLE
     && mode_ff == asi_panel_pkg::MODE_CONFIG)
    |=> system_fault_indicator_o && st_ff == asi_panel_pkg::ST_IDLE)
    else $error("slave 0 did not block protected mode");
  a_empty_defaults: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_ff == asi_panel_pkg::ST_STORE && (!pwr_ff || detected_i == 64'h0))
    |=> param_ff == 4'hF && auto_ff && expected_ff == 64'h0)
    else $error("defaults not restored on empty store");
  a_prot_exchange: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mode_ff == asi_panel_pkg::MODE_PROTECT && $past(mode_ff) == mode_ff
    |=> (exchange_en_o & ~$past(expected_ff)) == 64'h0)
    else $error("unconfigured slave in cyclic exchange");
endmodule
`default_nettype wire

// [asi_panel_defines.svh]
// Constants for the mode and front-panel block of the field-bus master.
// Assumes inclusion by bare name from the modules; the package does not include it.
`ifndef ASI_PANEL_DEFINES_SVH
`define ASI_PANEL_DEFINES_SVH

// =====================================================================
// Register offsets (byte addresses, aligned words; the expected set spans two words, each window 16 bytes)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_DETECTED    8'h08
`define REG_EXPECTED    8'h0C
`define REG_ACTIVE      8'h10
`define REG_PARAM       8'h14
`define REG_WIN_IN      8'h40
`define REG_WIN_OUT     8'h80
`define WIN_BYTES       16
// =====================================================================
// Control word fields
`define CTRL_CPU_STOP   0
`define CTRL_LOAD_CFG   1
`define CTRL_LINE_PWR   2
// Status word fields
`define STAT_CFG_MODE   0
`define STAT_CFG_ERR    1
`define STAT_SYS_FAULT  2
`define STAT_AUTO_ADDR  3
// =====================================================================
// Reset and default values
`define PARAM_DEFAULT   4'hF
`define AUTO_ADDR_RST   1'b1
`define UNMAPPED_DATA   32'hDEAD_BEEF
// Timing: clock 50 ns, rotation 500 ms, flash half period 250 ms
`define CLK_PERIOD_NS   50
`define ROTATE_MS       500
`define FLASH_MS        250
`define ROTATE_CYC      ((`ROTATE_MS * 1000000) / `CLK_PERIOD_NS)
`define FLASH_CYC       ((`FLASH_MS * 1000000) / `CLK_PERIOD_NS)
`define DEBOUNCE_CYC    4

`endif

// [asi_panel_pkg.sv]
// Types shared by the mode and front-panel block.
// Assumes nothing beyond a SystemVerilog compiler.
package asi_panel_pkg;
  // =====================================================================
  // Operating mode of the master
  typedef enum logic {
    MODE_CONFIG,
    MODE_PROTECT
  } mode_t;
  // Step of the store sequence
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STORE,
    ST_SWITCH
  } store_t;
endpackage

// [asi_button_sync.sv]
// Button synchroniser, debouncer and press-edge detector.
// Assumes a raw asynchronous push button, active high when pressed.
`timescale 1ns/1ns
`default_nettype none
`include "asi_panel_defines.svh"

module asi_button_sync #(
  parameter int DEBOUNCE = `DEBOUNCE_CYC
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic button_i,
  output logic      press_o
);
  // =====================================================================
  // Two-stage synchroniser; only the second stage is looked at
  logic       meta_ff;
  logic       sync_ff;
  logic       stable_ff;
  logic       press_ff;
  logic [3:0] cnt_ff;
  logic       nxt_stable;
  logic       nxt_press;
  logic [3:0] nxt_cnt;

  // Debounce: level must hold DEBOUNCE cycles before it is believed
  always_comb begin
    nxt_stable = stable_ff;
    nxt_press  = 1'b0;
    nxt_cnt    = 4'h0;
    if (sync_ff != stable_ff) begin
      nxt_cnt = cnt_ff + 4'h1;
      if (cnt_ff == 4'(DEBOUNCE - 1)) begin
        nxt_stable = sync_ff;
        nxt_press  = sync_ff;
        nxt_cnt    = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_ff   <= 1'b0;
      sync_ff   <= 1'b0;
      stable_ff <= 1'b0;
      press_ff  <= 1'b0;
      cnt_ff    <= 4'h0;
    end else begin
      meta_ff   <= button_i;
      sync_ff   <= meta_ff;
      stable_ff <= nxt_stable;
      press_ff  <= nxt_press;
      cnt_ff    <= nxt_cnt;
    end
  end

  assign press_o = press_ff;
endmodule
`default_nettype wire

// [plc_cpu_model.sv]
// Processor model: an Avalon-MM master that reaches the panel's registers.
// Assumes a slave that lowers waitrequest for one cycle per accepted request.
`timescale 1ns/1ns
`default_nettype none

module plc_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  output logic [7:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o
);
  // ====================================================================
  // Idle bus from time zero
  initial begin
    address_o   = 8'h00;
    read_o      = 1'b0;
    write_o     = 1'b0;
    writedata_o = 32'h0000_0000;
  end

  // ====================================================================
  // One transfer; held until waitrequest is seen low. A dead slave is left
  // to the bench watchdog. Startup configuration writes use this too.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    @(posedge clk_i);
    address_o   <= a; // Local offset; the slot base is decoded upstream
    writedata_o <= d;
    write_o     <= wr;
    read_o      <= ~wr;
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    ok = (waitrequest_i === 1'b0);
    q  = readdata_i;
    read_o  <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the mode and front-panel block.
// Assumes the processor model drives the register bus; slave sets come from here.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        clk, resetn, button, rd, wr, waitreq, t10, t20, area_b;
  logic        cm_ind, cer_ind, sf_ind, nv_write, nv_clr;
  logic [63:0] detected, cfg_match, exch;
  logic [31:0] slave_in, wdata, rdata, slave_out;
  logic [7:0]  address;
  logic [9:0]  unit_led, on, off;
  logic [7:0]  seen;
  int          err_count, samples_checked, nv_cnt;
  typedef struct packed {
    logic        stop;
    logic        pwr;
    logic [63:0] det;
    logic        cm;
    logic        sf;
    logic        nv;
  } row_t;
  row_t rows [5];

  // ====================================================================
  // Design with short rotation and flash counts
  asi_master_mode_panel #(.ROTATE_CYCLES(8), .FLASH_CYCLES(4)) u_asi_master_mode_panel (
    .clk_i(clk), .resetn_i(resetn), .button_i(button), .detected_i(detected),
    .cfg_match_i(cfg_match), .slave_in_i(slave_in), .avs_address_i(address),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .unit_led_o(unit_led),
    .tens10_led_o(t10), .tens20_led_o(t20), .area_b_led_o(area_b),
    .config_mode_indicator_o(cm_ind), .config_error_indicator_o(cer_ind),
    .system_fault_indicator_o(sf_ind), .exchange_en_o(exch),
    .slave_out_o(slave_out), .nv_write_o(nv_write));

  plc_cpu_model u_plc_cpu_model (
    .clk_i(clk), .waitrequest_i(waitreq), .readdata_i(rdata), .address_o(address),
    .read_o(rd), .write_o(wr), .writedata_o(wdata));

  // ====================================================================
  // Clock, store-pulse counter and watchdog
  always #25 clk = ~clk;

  // One process owns the counter; press() only asks for a clear
  always @(posedge clk) begin
    if (nv_clr) nv_cnt <= 0;
    else if (nv_write === 1'b1) nv_cnt <= nv_cnt + 1;
  end

  initial begin
    repeat (8000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ====================================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    u_plc_cpu_model.xfer(w, a, d, q, ok);
    chk({31'h0, ok, (w ? 32'h0 : q & mask)}, {31'h0, 1'b1, (w ? 32'h0 : exp)});
  endtask

  // Hold well past sync plus debounce, then let the mode settle
  task automatic press();
    @(posedge clk);
    nv_clr <= 1'b1;
    button <= 1'b1;
    @(posedge clk);
    nv_clr <= 1'b0;
    repeat (11) @(posedge clk);
    button <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // Only settled cycles of group zero count, so group-change lag is ignored
  task automatic observe();
    logic [2:0] g, pg;
    int         run;
    on = '0; off = '0; seen = '0; pg = 3'h0; run = 0;
    repeat (200) begin
      @(posedge clk);
      g = {area_b, t20, t10};
      run = (g == pg) ? run + 1 : 0;
      pg = g;
      seen[g] = 1'b1;
      if (g == 3'h0 && run >= 2) begin
        on  |= unit_led;
        off |= ~unit_led;
      end
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ====================================================================
  // Main sequence: press table first, then hand-written cases
  initial begin
    clk = 1'b0; resetn = 1'b0; button = 1'b0; detected = 64'h0;
    cfg_match = '1; slave_in = 32'hA5C3_96FF; err_count = 0; samples_checked = 0;
    nv_clr = 1'b0;
    rows[0] = '{1'b0, 1'b1, 64'h6, 1'b1, 1'b0, 1'b0};
    rows[1] = '{1'b1, 1'b1, 64'h7, 1'b1, 1'b1, 1'b0};
    rows[2] = '{1'b1, 1'b1, 64'h6, 1'b0, 1'b0, 1'b1};
    rows[3] = '{1'b1, 1'b1, 64'h6, 1'b1, 1'b0, 1'b0};
    rows[4] = '{1'b1, 1'b0, 64'h6, 1'b0, 1'b0, 1'b1};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(cm_ind, 1'b1);
    chk(sf_ind, 1'b0);
    // Clear parameter and auto-address so the unpowered store must restore them
    bus(1'b1, 8'h14, 32'h0, '0, '0);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, {29'h0, rows[i].pwr, 1'b0, rows[i].stop}, '0, '0);
      detected <= rows[i].det;
      press();
      chk(cm_ind, rows[i].cm);
      chk(sf_ind, rows[i].sf);
      chk(64'(nv_cnt), rows[i].nv);
      // Unpowered store empties the expected set, so present slaves mismatch again
      if (!rows[i].cm) chk(cer_ind, !rows[i].pwr);
    end
    // Store without line power leaves defaults behind
    bus(1'b0, 8'h14, '0, 32'h1F, 32'h1F);
    bus(1'b0, 8'h10, '0, '1, 32'h0);
    // Back to configuration mode; slave 0 never joins the exchange
    press();
    detected <= 64'hF;
    repeat (4) @(posedge clk);
    chk(exch, 64'hE);
    observe();
    chk({on[3:0], off[3:0]}, 8'hF_0);
    chk(seen[1:0], 2'b11);
    chk(|seen[7:4], 1'b1);
    // Store slaves 1 and 2, then attach 3 and spoil the data of 2
    detected <= 64'h6;
    bus(1'b1, 8'h00, 32'h5, '0, '0);
    press();
    chk(cm_ind, 1'b0);
    cfg_match <= ~64'h4;
    detected <= 64'hE;
    repeat (4) @(posedge clk);
    chk(exch, 64'h2);
    observe();
    chk({on[3:1], off[3:1]}, 6'b111_110);
    // Processor-loaded expected set overrides the button store
    bus(1'b1, 8'h0C, 32'hE, '0, '0);
    repeat (4) @(posedge clk);
    chk(exch, 64'hA);
    bus(1'b0, 8'h10, '0, '1, 32'hA);
    bus(1'b0, 8'h04, '0, 32'h1, 32'h0);
    bus(1'b0, 8'h20, '0, '1, 32'hDEAD_BEEF);
    // Window words: the reserved nibble reads as zero both ways
    bus(1'b0, 8'h4C, '0, '1, 32'hA5C3_96F0);
    bus(1'b1, 8'h8C, 32'h1234_567F, '0, '0);
    bus(1'b0, 8'h8C, '0, '1, 32'h1234_5670);
    chk(slave_out, 32'h1234_5670);
    // Second reset in mid-run returns to configuration mode
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(cm_ind, 1'b1);
    print_verdict();
  end
endmodule

`default_nettype wire
